/* rtl/stp_clkout_gate.sv */
// clock-output gate: stops the output clock at once or after a fixed number of output cycles
// assumes outTick pulses for one core cycle per clock-output period, from the same clock
`timescale 1ns/1ps
module stp_clkout_gate (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // requests
   input wire logic stopDelayed,
   input wire logic stopNow,
   input wire logic startReq,
   input wire logic outTick,
   // gate
   output logic clkOutEnable
);
   import stp_pkg::*;

   logic enable_r;
   logic counting_r;
   logic [CLKOUT_CNT_W-1:0] cnt_r;
   wire lastTick = counting_r && outTick && (cnt_r == CLKOUT_CNT_LAST);

   // restart wins: a frame arriving as the stop runs out must keep the host clocked
   always_ff @(posedge clk) begin
      if (srst) begin
         enable_r <= 1'b1;
         counting_r <= 1'b0;
         cnt_r <= CLKOUT_CNT_ZERO;
      end else if (startReq) begin
         enable_r <= 1'b1;
         counting_r <= 1'b0;
         cnt_r <= CLKOUT_CNT_ZERO;
      end else if (stopNow) begin
         enable_r <= 1'b0;
         counting_r <= 1'b0;
      end else if (stopDelayed) begin
         counting_r <= 1'b1;
         cnt_r <= CLKOUT_CNT_ZERO;
      end else if (lastTick) begin
         enable_r <= 1'b0;
         counting_r <= 1'b0;
      end else if (counting_r && outTick) begin
         cnt_r <= cnt_r + CLKOUT_CNT_ONE;
      end
   end

   assign clkOutEnable = enable_r;

   a_stop_only_last: assert property (@(posedge clk) disable iff (srst)
      $fell(enable_r) |-> $past(stopNow) || $past(lastTick))
      else $error("clock output stopped before its grace cycles ran out");

   a_immediate_stop: assert property (@(posedge clk) disable iff (srst)
      (stopNow && !startReq) |=> !enable_r)
      else $error("fast rate did not stop the clock output at once");

   a_restart_wins: assert property (@(posedge clk) disable iff (srst)
      startReq |=> enable_r && !counting_r)
      else $error("clock output not restarted");

endmodule : stp_clkout_gate

/* rtl/stp_pin_ctrl.sv */
// sleep/transmit pin control: turns the multi-purpose pin into triggers and state overlays
// assumes radioState comes from the transceiver state machine on clk, the pin is asynchronous
//
// Behaviour
// - in synth-ready or auto-retry state the pin triggers frame or retry transmit
// - those triggers fire on a rising edge only, never on fall or level
// - busy auto-ack receive in slotted mode: rising edge starts acknowledgement frame
// - idle off plus rising edge enters sleep and disables clock output
// - sleep returns to idle off whenever the pin is low, level sensitive
// - listen plus rising edge enters no-clock listen and stops clock output
// - no-clock listen plus falling edge returns to listen and restarts clock
// - auto-ack listen plus rising edge enters its no-clock variant, clock stops
// - no-clock auto-ack listen plus falling edge returns and restarts clock
// - pin-entered state is held while pin high, left on its fall
// - sleep entry keeps clock output for 35 more output cycles
// - listen no-clock entry also stops clock after 35 output cycles
// - rate select six or seven stops clock output immediately on entry
// - frame start in either no-clock listen state restarts clock output
`timescale 1ns/1ps
module stp_pin_ctrl (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // pin from the host
   input wire logic sleepTxPin,
   // transceiver context
   input wire stp_pkg::stp_radio_e radioState,
   input wire logic [stp_pkg::RATE_SEL_W-1:0] clockOutputRateSelect,
   input wire logic frameStart,
   input wire logic clkOutTick,
   // triggers to the transceiver
   output logic txStart,
   output logic autoRetryStart,
   output logic ackStart,
   // overlay state
   output stp_pkg::stp_mode_e pinMode,
   output logic sleepActive,
   output logic listenNoclk,
   output logic aackListenNoclk,
   // clock output gate
   output logic clockOutputEnable
);
   import stp_pkg::*;

   // two-stage synchroniser; the first stage feeds only the second
   logic pinMeta_r;
   logic pinSync_r;
   logic pinPrev_r;

   always_ff @(posedge clk) begin
      if (srst) begin
         pinMeta_r <= 1'b0;
         pinSync_r <= 1'b0;
         pinPrev_r <= 1'b0;
      end else begin
         pinMeta_r <= sleepTxPin;
         pinSync_r <= pinMeta_r;
         pinPrev_r <= pinSync_r;
      end
   end

   wire pinRise = pinSync_r && !pinPrev_r;
   wire pinFall = !pinSync_r && pinPrev_r;

   stp_mode_e mode_r;
   stp_mode_e mode_nxt;

   // a pin action fires only on a synchronised rise, in one radio state, with no overlay active
   function automatic logic riseIn(input logic normal, input logic rise, input stp_radio_e cur,
                                   input stp_radio_e want);
      return normal && rise && (cur == want);
   endfunction : riseIn

   // decode
   wire inNormal = (mode_r == MODE_NORMAL);
   wire rateFast = (clockOutputRateSelect == RATE_SEL_FAST_A) ||
                   (clockOutputRateSelect == RATE_SEL_FAST_B);
   wire trigSynth = riseIn(inNormal, pinRise, radioState, RADIO_SYNTH_READY);
   wire trigRetry = riseIn(inNormal, pinRise, radioState, RADIO_AUTO_RETRY_TX);
   wire trigAck = riseIn(inNormal, pinRise, radioState, RADIO_AUTO_ACK_RX_BUSY);
   wire goSleep = riseIn(inNormal, pinRise, radioState, RADIO_IDLE_OFF);
   wire goListenNc = riseIn(inNormal, pinRise, radioState, RADIO_LISTEN);
   wire goAackNc = riseIn(inNormal, pinRise, radioState, RADIO_AUTO_ACK_LISTEN);
   wire inNoclk = (mode_r == MODE_LISTEN_NOCLK) || (mode_r == MODE_AACK_LISTEN_NOCLK);
   wire leaveSleep = (mode_r == MODE_SLEEP) && !pinSync_r;
   wire leaveNoclk = inNoclk && pinFall;
   wire enterStop = goSleep || goListenNc || goAackNc;

   always_comb begin
      mode_nxt = mode_r;
      case (mode_r)
         MODE_NORMAL: begin
            if (goSleep) begin
               mode_nxt = MODE_SLEEP;
            end else if (goListenNc) begin
               mode_nxt = MODE_LISTEN_NOCLK;
            end else if (goAackNc) begin
               mode_nxt = MODE_AACK_LISTEN_NOCLK;
            end
         end
         MODE_SLEEP: begin
            if (leaveSleep) begin
               mode_nxt = MODE_NORMAL;
            end
         end
         MODE_LISTEN_NOCLK, MODE_AACK_LISTEN_NOCLK: begin
            if (pinFall) begin
               mode_nxt = MODE_NORMAL;
            end
         end
         default: begin
            mode_nxt = MODE_NORMAL;
         end
      endcase
   end

   logic txStart_r;
   logic autoRetryStart_r;
   logic ackStart_r;

   always_ff @(posedge clk) begin
      if (srst) begin
         mode_r <= MODE_NORMAL;
         txStart_r <= 1'b0;
         autoRetryStart_r <= 1'b0;
         ackStart_r <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         txStart_r <= trigSynth;
         autoRetryStart_r <= trigRetry;
         ackStart_r <= trigAck;
      end
   end

   // clock restart on wake, on return to listen, or on a frame starting while no-clock
   wire clkStart = leaveSleep || leaveNoclk || (inNoclk && frameStart);
   wire clkStopNow = enterStop && rateFast;
   wire clkStopLater = enterStop && !rateFast;

   stp_clkout_gate uGate (
      .clk(clk),
      .srst(srst),
      .stopDelayed(clkStopLater),
      .stopNow(clkStopNow),
      .startReq(clkStart),
      .outTick(clkOutTick),
      .clkOutEnable(clockOutputEnable)
   );

   assign txStart = txStart_r;
   assign autoRetryStart = autoRetryStart_r;
   assign ackStart = ackStart_r;
   assign pinMode = mode_r;
   assign sleepActive = (mode_r == MODE_SLEEP);
   assign listenNoclk = (mode_r == MODE_LISTEN_NOCLK);
   assign aackListenNoclk = (mode_r == MODE_AACK_LISTEN_NOCLK);

   // checks
   a_sync_delay: assert property (@(posedge clk) disable iff (srst)
      $rose(pinSync_r) |-> $past(sleepTxPin, 2))
      else $error("pin edge seen without two synchroniser stages");

   a_tx_rise: assert property (@(posedge clk) disable iff (srst)
      (inNormal && pinRise && radioState == RADIO_SYNTH_READY) |=> txStart)
      else $error("rising pin in synth-ready did not start transmit");

   a_tx_edge_only: assert property (@(posedge clk) disable iff (srst)
      txStart || autoRetryStart |-> $past(pinRise))
      else $error("transmit trigger without a rising edge");

   a_retry_rise: assert property (@(posedge clk) disable iff (srst)
      (inNormal && pinRise && radioState == RADIO_AUTO_RETRY_TX) |=> autoRetryStart)
      else $error("rising pin in auto-retry state did not start retry");

   a_ack_rise: assert property (@(posedge clk) disable iff (srst)
      (inNormal && pinRise && radioState == RADIO_AUTO_ACK_RX_BUSY) |=> ackStart)
      else $error("rising pin in busy auto-ack did not start acknowledgement");

   a_sleep_entry: assert property (@(posedge clk) disable iff (srst)
      (inNormal && pinRise && radioState == RADIO_IDLE_OFF) |=> sleepActive)
      else $error("idle off did not enter sleep");

   a_sleep_wake: assert property (@(posedge clk) disable iff (srst)
      (sleepActive && !pinSync_r) |=> !sleepActive ##1 clockOutputEnable)
      else $error("low pin did not wake from sleep");

   a_listen_noclk: assert property (@(posedge clk) disable iff (srst)
      (inNormal && pinRise && radioState == RADIO_LISTEN) |=> listenNoclk)
      else $error("listen did not enter no-clock listen");

   a_listen_back: assert property (@(posedge clk) disable iff (srst)
      (listenNoclk && pinFall) |=> !listenNoclk ##1 clockOutputEnable)
      else $error("falling pin did not return to listen with clock");

   a_aack_noclk: assert property (@(posedge clk) disable iff (srst)
      (inNormal && pinRise && radioState == RADIO_AUTO_ACK_LISTEN) |=> aackListenNoclk)
      else $error("auto-ack listen did not enter no-clock variant");

   a_aack_back: assert property (@(posedge clk) disable iff (srst)
      (aackListenNoclk && pinFall) |=> !aackListenNoclk ##1 clockOutputEnable)
      else $error("falling pin did not return to auto-ack listen");

   a_hold_high: assert property (@(posedge clk) disable iff (srst)
      (inNoclk && pinSync_r) |=> inNoclk)
      else $error("no-clock state left while pin still high");

   a_grace_clock: assert property (@(posedge clk) disable iff (srst)
      (enterStop && !rateFast) |=> clockOutputEnable [*2])
      else $error("clock output stopped without grace cycles");

   a_fast_stop: assert property (@(posedge clk) disable iff (srst)
      (enterStop && rateFast) |-> ##2 !clockOutputEnable)
      else $error("fast rate did not stop clock at once");

   a_frame_restart: assert property (@(posedge clk) disable iff (srst)
      (inNoclk && frameStart) |-> ##2 clockOutputEnable)
      else $error("frame start did not restart clock output");

   c_sleep_cycle: cover property (@(posedge clk) disable iff (srst)
      sleepActive ##[1:200] !sleepActive);

   c_listen_cycle: cover property (@(posedge clk) disable iff (srst)
      listenNoclk && frameStart ##[1:200] !listenNoclk);

   c_tx_trigger: cover property (@(posedge clk) disable iff (srst) txStart);

   c_grace_expiry: cover property (@(posedge clk) disable iff (srst)
      sleepActive && $fell(clockOutputEnable));

endmodule : stp_pin_ctrl

/* rtl/stp_pkg.sv */
// shared types and constants for the sleep/transmit pin control block
// assumes one 100 MHz core clock and a clock-output prescaler that pulses once per output cycle
package stp_pkg;

   // radio state as reported by the transceiver state machine
   typedef enum logic [2:0] {
      RADIO_OTHER,
      RADIO_SYNTH_READY,
      RADIO_AUTO_RETRY_TX,
      RADIO_AUTO_ACK_RX_BUSY,
      RADIO_IDLE_OFF,
      RADIO_LISTEN,
      RADIO_AUTO_ACK_LISTEN
   } stp_radio_e;

   // states that the pin itself holds the radio in
   typedef enum logic [1:0] {
      MODE_NORMAL,
      MODE_SLEEP,
      MODE_LISTEN_NOCLK,
      MODE_AACK_LISTEN_NOCLK
   } stp_mode_e;

   localparam int RATE_SEL_W = 3;
   localparam logic [RATE_SEL_W-1:0] RATE_SEL_FAST_A = 3'h6;
   localparam logic [RATE_SEL_W-1:0] RATE_SEL_FAST_B = 3'h7;

   // clock-output cycles granted to a host after a stop request
   localparam int CLKOUT_STOP_CYCLES = 35;
   localparam int CLKOUT_CNT_W = 6;
   localparam logic [CLKOUT_CNT_W-1:0] CLKOUT_CNT_LAST = 6'h22;
   localparam logic [CLKOUT_CNT_W-1:0] CLKOUT_CNT_ZERO = 6'h00;
   localparam logic [CLKOUT_CNT_W-1:0] CLKOUT_CNT_ONE = 6'h01;

endpackage : stp_pkg

/* sim/stp_host_model.sv */
// host model: the microcontroller side that drives the sleep/transmit pin
// assumes the bench asks for a pin level and the host moves the pin on the falling edge
`timescale 1ns/1ps
module stp_host_model (
   // clock
   input wire logic clk,
   // request from the bench
   input wire logic hostLevel,
   // pin to the device
   output logic sleepTxPin
);
   // the host holds the pin for as long as it wants the new state
   always @(negedge clk) begin
      sleepTxPin <= hostLevel;
   end
endmodule : stp_host_model

/* sim/tb.sv */
// self-checking bench for the sleep/transmit pin control block
// assumes a 100 MHz clock and a clock-output prescaler modelled as a tick every 4 cycles
`timescale 1ns/1ps
module tb;
   import stp_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic hostLevel = 1'b0;
   logic sleepTxPin;
   stp_radio_e radioState = RADIO_OTHER;
   logic [RATE_SEL_W-1:0] rateSel = 3'h0;
   logic frameStart = 1'b0;
   logic clkOutTick = 1'b0;
   logic txStart, autoRetryStart, ackStart, sleepActive, listenNoclk, aackListenNoclk;
   logic clockOutputEnable;
   stp_mode_e pinMode;
   int err_total = 0;
   int checks = 0;
   int tickPhase = 0;
   int txCnt = 0;
   int retryCnt = 0;
   int ackCnt = 0;
   int tickCnt = 0;
   logic enPrev = 1'b1;
   stp_mode_e modePrev = MODE_NORMAL;

   always #5 clk = ~clk;

   stp_host_model stp_host_model_i (.clk(clk), .hostLevel(hostLevel), .sleepTxPin(sleepTxPin));

   stp_pin_ctrl stp_pin_ctrl_i (
      .clk(clk), .srst(srst), .sleepTxPin(sleepTxPin), .radioState(radioState),
      .clockOutputRateSelect(rateSel), .frameStart(frameStart), .clkOutTick(clkOutTick),
      .txStart(txStart), .autoRetryStart(autoRetryStart), .ackStart(ackStart),
      .pinMode(pinMode), .sleepActive(sleepActive), .listenNoclk(listenNoclk),
      .aackListenNoclk(aackListenNoclk), .clockOutputEnable(clockOutputEnable)
   );

   // prescaler stand-in and event counters, all on the falling edge where outputs are settled
   always @(negedge clk) begin
      tickPhase <= (tickPhase + 1) % 4;
      clkOutTick <= (tickPhase == 3);
      if (txStart === 1'b1) txCnt <= txCnt + 1;
      if (autoRetryStart === 1'b1) retryCnt <= retryCnt + 1;
      if (ackStart === 1'b1) ackCnt <= ackCnt + 1;
      enPrev <= clockOutputEnable;
      modePrev <= pinMode;
      // judge each tick by the state before the edge that sampled it, as the gate does
      if (clkOutTick === 1'b1 && modePrev !== MODE_NORMAL && enPrev === 1'b1)
         tickCnt <= tickCnt + 1;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic setPin(input logic lvl, input int waitCyc);
      @(negedge clk) hostLevel <= lvl;
      repeat (waitCyc) @(negedge clk);
   endtask : setPin

   // one rising edge held high: exactly one pulse on the output that belongs to the state, no pulse in RADIO_OTHER
   task automatic test_trigger(input stp_radio_e st, input logic [7:0] exp);
      @(negedge clk) radioState <= st;
      txCnt = 0;
      retryCnt = 0;
      ackCnt = 0;
      setPin(1'b1, 12);
      setPin(1'b0, 12);
      chk(8'(txCnt * 16 + retryCnt * 4 + ackCnt), exp);
      chk(8'(pinMode), 8'(MODE_NORMAL));
      $display("trigger test done for state %0d", st);
   endtask : test_trigger

   // pin-held overlay: entry, clock-output stop, optional frame restart, return on release
   task automatic test_overlay(input stp_radio_e st, input logic [2:0] rate, input stp_mode_e md);
      logic fast;
      logic [7:0] gotState;
      logic [7:0] expEntry;
      fast = (rate == RATE_SEL_FAST_A) || (rate == RATE_SEL_FAST_B);
      expEntry = {2'h0, 2'(md), ~fast, md == MODE_SLEEP, md == MODE_LISTEN_NOCLK,
                  md == MODE_AACK_LISTEN_NOCLK};
      @(negedge clk) begin
         radioState <= st;
         rateSel <= rate;
      end
      tickCnt = 0;
      setPin(1'b1, 8);
      gotState = {2'h0, 2'(pinMode), clockOutputEnable, sleepActive, listenNoclk,
                  aackListenNoclk};
      chk(gotState, expEntry);
      if (!fast) begin
         repeat (200) @(negedge clk);
         chk({clockOutputEnable, 7'(tickCnt)}, {1'b0, 7'd35});
      end
      if (md != MODE_SLEEP) begin
         @(negedge clk) frameStart <= 1'b1;
         @(negedge clk) frameStart <= 1'b0;
         repeat (4) @(negedge clk);
         chk({5'h0, 2'(pinMode), clockOutputEnable}, {5'h0, 2'(md), 1'b1});
      end
      setPin(1'b0, 8);
      chk({5'h0, 2'(pinMode), clockOutputEnable}, {5'h0, 2'(MODE_NORMAL), 1'b1});
      chk({5'h0, sleepActive, listenNoclk, aackListenNoclk}, 8'h00);
      $display("overlay test done for state %0d rate %0d", st, rate);
   endtask : test_overlay

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (8) @(negedge clk);
      srst <= 1'b0;
      repeat (2) @(negedge clk);
      test_trigger(RADIO_SYNTH_READY, 8'h10);
      test_trigger(RADIO_AUTO_RETRY_TX, 8'h04);
      test_trigger(RADIO_AUTO_ACK_RX_BUSY, 8'h01);
      test_trigger(RADIO_OTHER, 8'h00);
      test_overlay(RADIO_IDLE_OFF, 3'h0, MODE_SLEEP);
      test_overlay(RADIO_LISTEN, 3'h0, MODE_LISTEN_NOCLK);
      test_overlay(RADIO_AUTO_ACK_LISTEN, 3'h7, MODE_AACK_LISTEN_NOCLK);
      test_overlay(RADIO_IDLE_OFF, 3'h6, MODE_SLEEP);
      report_and_stop();
   end

   // the run needs about 600 cycles; the 10000-cycle limit, over sixteen times that, means a hang
   initial begin
      #100000;
      err_total++;
      report_and_stop();
   end
endmodule : tb
